// ---- rtl/epp_cfg.svh ----
`ifndef EPP_CFG_SVH
`define EPP_CFG_SVH
// Parallel action select and byte select encodings.
`define EPP_ACT_ADDR    2'b00
`define EPP_ACT_DATA    2'b01
`define EPP_ACT_CMD     2'b10
`define EPP_BS_LO       2'b00
`define EPP_BS_HI       2'b01
`define EPP_BS_EXT      2'b10
`define EPP_BS_FHI      2'b11
// Parallel command bytes.
`define EPP_CMD_NOP     8'h00
`define EPP_CMD_ERASE   8'h80
`define EPP_CMD_WFUSE   8'h40
`define EPP_CMD_WLOCK   8'h20
`define EPP_CMD_WFLASH  8'h10
`define EPP_CMD_WEE     8'h11
`define EPP_CMD_RSIG    8'h08
`define EPP_CMD_RFUSE   8'h04
`define EPP_CMD_RFLASH  8'h02
`define EPP_CMD_REE     8'h03
// Serial instruction bytes.
`define EPP_SER_PREFIX  8'hAC
`define EPP_SER_ENABLE  8'h53
`define EPP_SER_ERASE   3'b100
`define EPP_SER_WLOCK   3'b111
`define EPP_SER_FUSELO  8'hA0
`define EPP_SER_FUSEHI  8'hA8
`define EPP_SER_FUSEEX  8'hA4
`define EPP_SER_LDEXT   8'h4D
`define EPP_SER_RDPROG  4'h2
`define EPP_SER_LDPAGE  8'h40
`define EPP_SER_LDPGHI  8'h48
`define EPP_SER_WRPAGE  8'h4C
`define EPP_SER_RDEE    8'hA0
`define EPP_SER_WREE    8'hC0
`define EPP_SER_RDLOCK  8'h58
`define EPP_SER_RDFUSE  8'h50
`define EPP_SER_RDSIG   8'h30
`define EPP_SER_HISEL   8'h08
// Storage and reset values.
`define EPP_ERASED8     8'hFF
`define EPP_ERASED16    16'hFFFF
`define EPP_FUSE_INIT   8'hFF
`define EPP_LOCK_INIT   8'hFF
`define EPP_FLASH_WORDS 256
`define EPP_EE_BYTES    64
`define EPP_EE_PAGE     4
// Wait delays in milliseconds and the clock rate in MHz.
`define EPP_CLK_MHZ         200
`define EPP_FLASH_WAIT_MS   4.5
`define EPP_EE_WAIT_MS      9.0
`define EPP_ERASE_WAIT_MS   9.0
`endif

// ---- rtl/epp_pkg.sv ----
package epp_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_FLASH, OP_EE, OP_ERASE, OP_FUSE, OP_LOCK
    } epp_op_t;
endpackage : epp_pkg

// ---- rtl/epp_top.sv ----
`include "epp_cfg.svh"
// ----------------------------------------------------------------------
// Overview of operation
// - Action select 10/00/01 loads command/address/data on load strobe rise.
// - Loading the no-operation command clears internal write signals.
// - EEPROM command; page latch stores bytes into the page buffer.
// - Write low pulse with selects 00 programs EEPROM page; busy low.
// - Flash read drives low byte or high byte by low select.
// - EEPROM read drives addressed byte while output drive low.
// - Fuse command plus data; write pulse commits, busy until done.
// - Selects 01 commit high fuses, 10 extended fuses.
// - Lock command plus data; zero bits program lock bits.
// - At lock level 3 boot lock bits cannot be programmed.
// - Lock bits return unprogrammed only through chip erase or srst.
// - Fuse/lock read: 00 low, 11 high, 10 extended, 01 lock.
// - Signature command drives identification byte 0 to 2.
// - Signature command, address 0, select 1 drives calibration byte.
// - Serial mode only under reset low; enable instruction first.
// - Serial EEPROM byte write overwrites without prior erase.
// - Chip erase sets flash and EEPROM to 0xFF.
// - Serial bits sampled on clock rise, shifted out on fall.
// - Enable second byte 0x53 echoes during the third byte.
// - Serial page load by 7 address bits, low then high; ext kept.
// ----------------------------------------------------------------------
module epp_top #(
    parameter int FLASH_WAIT_CYC = int'(`EPP_FLASH_WAIT_MS*1000.0*`EPP_CLK_MHZ),
    parameter int EE_WAIT_CYC    = int'(`EPP_EE_WAIT_MS*1000.0*`EPP_CLK_MHZ),
    parameter int ERASE_WAIT_CYC = int'(`EPP_ERASE_WAIT_MS*1000.0*`EPP_CLK_MHZ),
    parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE2 = 8'h33, // Arbitrary value.
    parameter logic [7:0] CAL_BYTE  = 8'h80  // Arbitrary value.
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       par_mode,
    input  wire logic       action_sel_hi,
    input  wire logic       action_sel_lo,
    input  wire logic       byte_select_hi,
    input  wire logic       byte_select_lo,
    input  wire logic       load_strobe_clock,
    input  wire logic       page_latch_strobe,
    input  wire logic       write_n,
    input  wire logic       output_drive_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_flag,
    input  wire logic       prog_reset_n,
    input  wire logic       serial_clk,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int NPIN = 20;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_q;
    always_ff @(posedge clk) begin
        pin_s1 <= {par_mode, action_sel_hi, action_sel_lo, byte_select_hi,
                   byte_select_lo, load_strobe_clock, page_latch_strobe,
                   write_n, output_drive_n, data_in, prog_reset_n,
                   serial_clk, serial_in_pin};
        pin_s2 <= pin_s1;
        pin_q  <= pin_s2;
    end
    logic       pm;
    logic [1:0] act;
    logic [1:0] bs;
    logic [7:0] din;
    logic       ld_rise;
    logic       pl_rise;
    logic       wr_fall;
    logic       oe_n;
    logic       ser_on;
    logic       sck_rise;
    logic       sck_fall;
    logic       sdi;
    assign pm       = pin_s2[19];
    assign act      = pin_s2[18:17];
    assign bs       = pin_s2[16:15];
    assign ld_rise  = pin_s2[14] & ~pin_q[14];
    assign pl_rise  = pin_s2[13] & ~pin_q[13];
    assign wr_fall  = ~pin_s2[12] & pin_q[12];
    assign oe_n     = pin_s2[11];
    assign din      = pin_s2[10:3];
    assign ser_on   = ~pin_s2[2];
    assign sck_rise = pin_s2[1] & ~pin_q[1];
    assign sck_fall = ~pin_s2[1] & pin_q[1];
    assign sdi      = pin_s2[0];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] flash [`EPP_FLASH_WORDS];
    logic [15:0] fbuf [`EPP_FLASH_WORDS/2];
    logic [7:0]  eep [`EPP_EE_BYTES];
    logic [7:0]  ebuf [`EPP_EE_PAGE];
    logic [`EPP_EE_PAGE-1:0] ebuf_vld;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  fuse_ex;
    logic [7:0]  lock;
    logic [20:0] busy_cnt;
    logic        busy;
    assign busy = busy_cnt != 21'd0;

    // ------------------------------------------------------------------
    // Parallel port
    // ------------------------------------------------------------------
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] dat_lo;
    logic [7:0] dat_hi;
    logic       armed;
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd     <= `EPP_CMD_NOP;
            addr_lo <= 8'h00;
            dat_lo  <= 8'h00;
            dat_hi  <= 8'h00;
            armed   <= 1'b0;
        end else if (pm && ld_rise) begin
            unique case (act)
                `EPP_ACT_CMD: begin
                    cmd <= din;
                    if (din == `EPP_CMD_NOP)
                        armed <= 1'b0;
                end
                `EPP_ACT_ADDR: if (bs == `EPP_BS_LO) addr_lo <= din;
                `EPP_ACT_DATA: begin
                    if (bs[0])
                        dat_hi <= din;
                    else
                        dat_lo <= din;
                end
                default: ;
            endcase
        end else if (pm && pl_rise) begin
            armed <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    logic [31:0] sh_in;
    logic [31:0] nxt;
    logic [4:0]  bit_cnt;
    logic [7:0]  sh_out;
    logic        prog_en;
    logic [7:0]  ext_addr;
    logic [7:0]  rd_byte;
    logic        ser_exec;
    assign nxt      = {sh_in[30:0], sdi};
    assign ser_exec = ser_on && sck_rise && bit_cnt == 5'd31;

    always_comb begin
        rd_byte = 8'h00;
        if (prog_en) begin
            if (nxt[23:20] == `EPP_SER_RDPROG)
                rd_byte = nxt[19] ? flash[nxt[7:0]][15:8]
                                  : flash[nxt[7:0]][7:0];
            else if (nxt[23:16] == `EPP_SER_RDEE)
                rd_byte = eep[nxt[5:0]];
            else if (nxt[23:16] == `EPP_SER_RDLOCK)
                rd_byte = nxt[15:8] == `EPP_SER_HISEL ? fuse_hi : lock;
            else if (nxt[23:16] == `EPP_SER_RDFUSE)
                rd_byte = nxt[15:8] == `EPP_SER_HISEL ? fuse_ex : fuse_lo;
            else if (nxt[23:16] == `EPP_SER_RDSIG)
                rd_byte = nxt[1:0] == 2'd0 ? SIG_BYTE0
                        : nxt[1:0] == 2'd1 ? SIG_BYTE1 : SIG_BYTE2;
        end
    end

    // Edges are taken only while programming reset is low, so a clock
    // that wanders during normal operation cannot disturb the framing.
    always_ff @(posedge clk) begin
        if (srst || !ser_on) begin
            sh_in          <= 32'h0000_0000;
            bit_cnt        <= 5'd0;
            sh_out         <= 8'h00;
            serial_out_pin <= 1'b0;
            prog_en        <= 1'b0;
            ext_addr       <= 8'h00;
        end else if (sck_rise) begin
            sh_in   <= nxt;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'd15)
                sh_out <= nxt[7:0];
            else if (bit_cnt == 5'd23)
                sh_out <= rd_byte;
            else if (bit_cnt[2:0] == 3'd7)
                sh_out <= 8'h00;
            if (ser_exec && nxt[31:24] == `EPP_SER_PREFIX
                    && nxt[23:16] == `EPP_SER_ENABLE)
                prog_en <= 1'b1;
            if (ser_exec && prog_en && nxt[31:24] == `EPP_SER_LDEXT)
                ext_addr <= nxt[15:8];
        end else if (sck_fall) begin
            serial_out_pin <= sh_out[7];
            sh_out         <= {sh_out[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Write requests from both paths
    // ------------------------------------------------------------------
    logic   p_wr;
    logic   s_wr;
    logic   do_erase;
    logic   do_fcommit;
    logic   fpage;
    logic   do_ecommit;
    logic   do_ebyte;
    logic   do_lock;
    logic   do_fuse;
    logic [1:0] fuse_sel;
    logic [7:0] wdat;
    epp_pkg::epp_op_t op;
    assign p_wr = pm && wr_fall && !busy;
    assign s_wr = ser_exec && prog_en && !busy;

    always_comb begin
        do_erase   = 1'b0;
        do_fcommit = 1'b0;
        do_ecommit = 1'b0;
        do_ebyte   = 1'b0;
        do_lock    = 1'b0;
        do_fuse    = 1'b0;
        fuse_sel   = `EPP_BS_LO;
        fpage      = addr_lo[7];
        wdat       = dat_lo;
        op         = epp_pkg::OP_NONE;
        if (p_wr) begin
            unique case (cmd)
                `EPP_CMD_ERASE:  do_erase   = 1'b1;
                `EPP_CMD_WFLASH: do_fcommit = armed;
                `EPP_CMD_WEE:    do_ecommit = bs == `EPP_BS_LO;
                `EPP_CMD_WFUSE: begin
                    do_fuse  = 1'b1;
                    fuse_sel = bs;
                end
                `EPP_CMD_WLOCK:  do_lock    = 1'b1;
                default: ;
            endcase
        end else if (s_wr) begin
            wdat  = nxt[7:0];
            fpage = nxt[15];
            if (nxt[31:24] == `EPP_SER_PREFIX) begin
                do_erase = nxt[23:21] == `EPP_SER_ERASE;
                do_lock  = nxt[23:21] == `EPP_SER_WLOCK;
                do_fuse  = nxt[23:16] == `EPP_SER_FUSELO
                         || nxt[23:16] == `EPP_SER_FUSEHI
                         || nxt[23:16] == `EPP_SER_FUSEEX;
                fuse_sel = nxt[23:16] == `EPP_SER_FUSEHI ? `EPP_BS_HI
                         : nxt[23:16] == `EPP_SER_FUSEEX ? `EPP_BS_EXT
                         : `EPP_BS_LO;
            end
            do_fcommit = nxt[31:24] == `EPP_SER_WRPAGE;
            do_ebyte   = nxt[31:24] == `EPP_SER_WREE;
        end
        if (do_erase)
            op = epp_pkg::OP_ERASE;
        else if (do_fcommit)
            op = epp_pkg::OP_FLASH;
        else if (do_ecommit || do_ebyte)
            op = epp_pkg::OP_EE;
        else if (do_fuse)
            op = epp_pkg::OP_FUSE;
        else if (do_lock)
            op = epp_pkg::OP_LOCK;
    end

    // ------------------------------------------------------------------
    // Memory arrays
    // ------------------------------------------------------------------
    logic s_ld;
    assign s_ld = ser_exec && prog_en
               && (nxt[31:24] == `EPP_SER_LDPAGE
                   || nxt[31:24] == `EPP_SER_LDPGHI);
    for (genvar i = 0; i < `EPP_FLASH_WORDS; i++) begin : g_flash
        always_ff @(posedge clk) begin
            if (srst || do_erase)
                flash[i] <= `EPP_ERASED16;
            else if (do_fcommit && fpage == 1'(i / 128))
                flash[i] <= fbuf[i%128];
        end
        if (i < `EPP_FLASH_WORDS/2) begin : g_buf
            always_ff @(posedge clk) begin
                if (srst)
                    fbuf[i] <= `EPP_ERASED16;
                else if (pm && pl_rise && addr_lo[6:0] == 7'(i))
                    fbuf[i] <= {dat_hi, dat_lo};
                else if (s_ld && nxt[14:8] == 7'(i) && !nxt[27])
                    fbuf[i][7:0] <= nxt[7:0];
                else if (s_ld && nxt[14:8] == 7'(i))
                    fbuf[i][15:8] <= nxt[7:0];
            end
        end
    end
    for (genvar j = 0; j < `EPP_EE_BYTES; j++) begin : g_ee
        always_ff @(posedge clk) begin
            if (srst || do_erase)
                eep[j] <= `EPP_ERASED8;
            else if (do_ebyte && nxt[13:8] == 6'(j))
                eep[j] <= nxt[7:0];
            else if (do_ecommit && addr_lo[5:2] == 4'(j / 4)
                     && ebuf_vld[j%4])
                eep[j] <= eep[j] & ebuf[j%4];
        end
        if (j < `EPP_EE_PAGE) begin : g_ebuf
            always_ff @(posedge clk) begin
                if (srst) begin
                    ebuf[j]     <= `EPP_ERASED8;
                    ebuf_vld[j] <= 1'b0;
                end else if (pm && ld_rise && act == `EPP_ACT_CMD
                             && din == `EPP_CMD_NOP) begin
                    ebuf_vld[j] <= 1'b0;
                end else if (do_ecommit) begin
                    ebuf_vld[j] <= 1'b0;
                end else if (pm && pl_rise && cmd == `EPP_CMD_WEE
                             && addr_lo[1:0] == 2'(j)) begin
                    ebuf[j]     <= dat_lo;
                    ebuf_vld[j] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Fuses, lock bits and busy timer
    // ------------------------------------------------------------------
    logic lvl3;
    assign lvl3 = lock[1:0] == 2'b00;
    always_ff @(posedge clk) begin
        if (srst) begin
            fuse_lo <= `EPP_FUSE_INIT;
            fuse_hi <= `EPP_FUSE_INIT;
            fuse_ex <= `EPP_FUSE_INIT;
        end else if (do_fuse) begin
            unique case (fuse_sel)
                `EPP_BS_LO:  fuse_lo <= wdat;
                `EPP_BS_HI:  fuse_hi <= wdat;
                `EPP_BS_EXT: fuse_ex <= wdat;
                default: ;
            endcase
        end
    end
    // Writes only AND new zeros in, so a lock write can never unprogram.
    always_ff @(posedge clk) begin
        if (srst || do_erase)
            lock <= `EPP_LOCK_INIT;
        else if (do_lock)
            lock <= lock & (lvl3 ? {wdat[7:6], 4'hF, wdat[1:0]}
                                 : wdat);
    end
    always_ff @(posedge clk) begin
        if (srst)
            busy_cnt <= 21'd0;
        else if (op == epp_pkg::OP_FLASH)
            busy_cnt <= 21'(FLASH_WAIT_CYC);
        else if (op == epp_pkg::OP_ERASE)
            busy_cnt <= 21'(ERASE_WAIT_CYC);
        else if (op != epp_pkg::OP_NONE)
            busy_cnt <= 21'(EE_WAIT_CYC);
        else if (busy)
            busy_cnt <= busy_cnt - 21'd1;
    end
    always_ff @(posedge clk) begin
        if (srst)
            ready_busy_flag <= 1'b1;
        else
            ready_busy_flag <= !busy && op == epp_pkg::OP_NONE;
    end

    // ------------------------------------------------------------------
    // Parallel read-back
    // ------------------------------------------------------------------
    logic [7:0] next_data_out;
    always_comb begin
        next_data_out = 8'h00;
        unique case (cmd)
            `EPP_CMD_RFLASH: next_data_out = bs[0] ? flash[addr_lo][15:8]
                                                   : flash[addr_lo][7:0];
            `EPP_CMD_REE:    next_data_out = eep[addr_lo[5:0]];
            `EPP_CMD_RFUSE: begin
                unique case (bs)
                    `EPP_BS_LO:  next_data_out = fuse_lo;
                    `EPP_BS_FHI: next_data_out = fuse_hi;
                    `EPP_BS_EXT: next_data_out = fuse_ex;
                    `EPP_BS_HI:  next_data_out = lock;
                endcase
            end
            `EPP_CMD_RSIG: begin
                if (bs[0])
                    next_data_out = CAL_BYTE;
                else if (addr_lo == 8'h00)
                    next_data_out = SIG_BYTE0;
                else if (addr_lo == 8'h01)
                    next_data_out = SIG_BYTE1;
                else if (addr_lo == 8'h02)
                    next_data_out = SIG_BYTE2;
            end
            default: ;
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe  <= pm && !oe_n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    nop_clears_arm_a: assert property (pm && ld_rise && act == `EPP_ACT_CMD
        && din == `EPP_CMD_NOP |=> !armed)
        else $error("nop did not clear write arm");
    busy_after_op_a: assert property (op != epp_pkg::OP_NONE
        |=> !ready_busy_flag [*2])
        else $error("ready not low after write start");
    oe_follows_a: assert property ($fell(oe_n) && pm |=> data_oe)
        else $error("data bus not driven");
    lock_no_clear_a: assert property (!do_erase
        |=> (lock & ~$past(lock)) == 8'h00)
        else $error("lock bit cleared without erase");
    boot_lock_keep_a: assert property (do_lock && lvl3
        |=> lock[5:2] == $past(lock[5:2]))
        else $error("boot lock changed at level 3");
    no_exec_unenabled_a: assert property (!prog_en && !pm
        |-> !do_erase && !do_ebyte)
        else $error("serial write before enable");
    erase_fills_a: assert property (do_erase
        |=> flash[0] == `EPP_ERASED16 && eep[0] == `EPP_ERASED8)
        else $error("erase did not fill memory");
    echo_load_a: assert property (ser_on && sck_rise && bit_cnt == 5'd15
        |=> sh_out == $past(nxt[7:0]))
        else $error("second byte not echoed");
    ee_overwrite_a: assert property (do_ebyte && !do_erase
        |=> eep[$past(nxt[13:8])] == $past(nxt[7:0]))
        else $error("serial eeprom byte not written");

    erase_c: cover property (do_erase);
    flash_commit_c: cover property (do_fcommit ##[1:10] !ready_busy_flag);
    enable_c: cover property ($rose(prog_en));
    fuse_read_c: cover property (data_oe && cmd == `EPP_CMD_RFUSE);
endmodule : epp_top

// ---- tb/epp_ser_prog.sv ----
// Serial programmer model: sends 32-bit instructions MSB first.
module epp_ser_prog (
    input  wire logic sdo,
    output logic      sck,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
    end
    // The clock stands low between frames, as a real programmer leaves it.
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            sdi = tx[i];
            #62;
            sck = 1'b1;
            rx[i] = sdo;
            #63;
            sck = 1'b0;
        end
        sdi = ~sdi;
    endtask : xfer
endmodule : epp_ser_prog

// ---- tb/epp_tb_top.sv ----
module epp_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Signature values are arbitrary.
    localparam logic [7:0] SIG [3] = '{8'h3c, 8'h4d, 8'h5e};
    localparam logic [7:0] CAL = 8'h77;
    logic        clk = 0, srst = 1, par_mode = 1, lsc = 0, pls = 0;
    logic        write_n = 1, oe_n = 1, prst_n = 1;
    logic  [1:0] act = 2'b11, bs = 2'b00;
    logic  [7:0] din = 8'h00, data_out;
    logic        data_oe, rdy, sck, sdi, sdo;
    logic [31:0] rx;
    int          n_fail = 0, n_tests = 0, cyc_cnt = 0;
    epp_top #(.FLASH_WAIT_CYC(20), .EE_WAIT_CYC(20), .ERASE_WAIT_CYC(20),
        .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]),
        .CAL_BYTE(CAL)) uut (
        .clk(clk), .srst(srst), .par_mode(par_mode),
        .action_sel_hi(act[1]), .action_sel_lo(act[0]),
        .byte_select_hi(bs[1]), .byte_select_lo(bs[0]),
        .load_strobe_clock(lsc), .page_latch_strobe(pls),
        .write_n(write_n), .output_drive_n(oe_n), .data_in(din),
        .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(rdy),
        .prog_reset_n(prst_n), .serial_clk(sck), .serial_in_pin(sdi),
        .serial_out_pin(sdo));
    epp_ser_prog prog (.sdo(sdo), .sck(sck), .sdi(sdi));
    initial forever #2.5 clk = ~clk;
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task chk(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Pins are held six cycles so the synchroniser sees every level.
    task cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task ld(logic [1:0] a, logic [1:0] b, logic [7:0] d);
        act = a;
        bs = b;
        din = d;
        cyc(6);
        lsc = 1;
        cyc(6);
        lsc = 0;
        cyc(6);
    endtask : ld
    task wait_rdy();
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        chk(8'(rdy), 8'h01);
    endtask : wait_rdy
    task wr(logic [1:0] b);
        bs = b;
        cyc(6);
        write_n = 0;
        cyc(6);
        write_n = 1;
        chk(8'(rdy), 8'h00);
        wait_rdy();
        bs = 2'b00;
        cyc(4);
    endtask : wr
    task rd(logic [1:0] b, logic [7:0] e);
        bs = b;
        oe_n = 0;
        cyc(6);
        chk(data_out, e);
        chk(8'(data_oe), 8'h01);
        oe_n = 1;
        cyc(6);
        chk(8'(data_oe), 8'h00);
    endtask : rd
    task test_fuse();
        ld(2'b10, 2'b00, 8'h04);
        rd(2'b00, 8'hFF);
        ld(2'b10, 2'b00, 8'h40);
        ld(2'b01, 2'b00, 8'hA5);
        wr(2'b01);
        ld(2'b10, 2'b00, 8'h04);
        rd(2'b11, 8'hA5);
        rd(2'b00, 8'hFF);
        $display("fuse test done");
    endtask : test_fuse
    task test_ee();
        ld(2'b10, 2'b00, 8'h11);
        ld(2'b00, 2'b00, 8'h05);
        ld(2'b01, 2'b00, 8'h3C);
        pls = 1;
        cyc(6);
        pls = 0;
        cyc(6);
        wr(2'b00);
        ld(2'b10, 2'b00, 8'h00);
        ld(2'b10, 2'b00, 8'h03);
        ld(2'b00, 2'b00, 8'h05);
        rd(2'b00, 8'h3C);
        $display("eeprom test done");
    endtask : test_ee
    task test_lock();
        ld(2'b10, 2'b00, 8'h20);
        ld(2'b01, 2'b00, 8'hFC);
        wr(2'b00);
        ld(2'b01, 2'b00, 8'hF0);
        wr(2'b00);
        ld(2'b01, 2'b00, 8'hFF);
        wr(2'b00);
        ld(2'b10, 2'b00, 8'h04);
        rd(2'b01, 8'hFC);
        ld(2'b10, 2'b00, 8'h80);
        wr(2'b00);
        ld(2'b10, 2'b00, 8'h04);
        rd(2'b01, 8'hFF);
        ld(2'b10, 2'b00, 8'h03);
        ld(2'b00, 2'b00, 8'h05);
        rd(2'b00, 8'hFF);
        $display("lock test done");
    endtask : test_lock
    task test_sig();
        ld(2'b10, 2'b00, 8'h08);
        for (int i = 0; i < 3; i++) begin
            ld(2'b00, 2'b00, 8'(i));
            rd(2'b00, SIG[i]);
        end
        ld(2'b00, 2'b00, 8'h00);
        rd(2'b01, CAL);
        $display("signature test done");
    endtask : test_sig
    task test_flash();
        ld(2'b10, 2'b00, 8'h10);
        ld(2'b00, 2'b00, 8'h03);
        ld(2'b01, 2'b00, 8'hC3);
        ld(2'b01, 2'b01, 8'h5A);
        pls = 1;
        cyc(6);
        pls = 0;
        cyc(6);
        wr(2'b00);
        ld(2'b10, 2'b00, 8'h00);
        ld(2'b10, 2'b00, 8'h10);
        write_n = 0;
        cyc(6);
        write_n = 1;
        chk(8'(rdy), 8'h01);
        cyc(4);
        ld(2'b10, 2'b00, 8'h02);
        ld(2'b00, 2'b00, 8'h03);
        rd(2'b00, 8'hC3);
        rd(2'b01, 8'h5A);
        $display("flash test done");
    endtask : test_flash
    task test_ser();
        par_mode = 0;
        prst_n = 0;
        cyc(4);
        prog.xfer(32'hC000_075A, rx);
        prst_n = 1;
        cyc(4);
        prst_n = 0;
        cyc(30);
        prog.xfer(32'hAC53_0000, rx);
        chk(rx[15:8], 8'h53);
        prog.xfer(32'hA000_0700, rx);
        chk(rx[7:0], 8'hFF);
        prog.xfer(32'hC000_075A, rx);
        wait_rdy();
        prog.xfer(32'hC000_07A5, rx);
        wait_rdy();
        prog.xfer(32'hA000_0700, rx);
        chk(rx[7:0], 8'hA5);
        prog.xfer(32'h4000_0412, rx);
        prog.xfer(32'h4800_0434, rx);
        prog.xfer(32'h4C00_0000, rx);
        wait_rdy();
        prog.xfer(32'h2000_0400, rx);
        chk(rx[7:0], 8'h12);
        prog.xfer(32'h2800_0400, rx);
        chk(rx[7:0], 8'h34);
        $display("serial test done");
    endtask : test_ser
    initial begin
        cyc(5);
        srst = 0;
        cyc(4);
        chk(8'(rdy), 8'h01);
        test_fuse();
        test_ee();
        test_lock();
        test_sig();
        test_flash();
        test_ser();
        print_verdict();
    end
endmodule : epp_tb_top
